// [hw/ddc_defs.svh]
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
`define DDC_IDX_DATAPATH 12'h002
`define DDC_IDX_CURRENT 12'h003
`define DDC_IDX_PATTERN 12'h004
`define DDC_OFF_DATAPATH (`DDC_IDX_DATAPATH * 12'h004)
`define DDC_OFF_CURRENT (`DDC_IDX_CURRENT * 12'h004)
`define DDC_OFF_PATTERN (`DDC_IDX_PATTERN * 12'h004)
`define DDC_OFF_IRQ_STATUS 12'h040
`define DDC_OFF_IRQ_MASK 12'h044
`define DDC_OFF_CHECK_CTRL 12'h048
`define DDC_RST_DATAPATH 16'h7000
`define DDC_RST_CURRENT 16'hf000
`define DDC_DP_WMASK 16'hf0fa
`define DDC_CUR_WMASK 16'hf001
`define DDC_BIT_FOUR_WIRE 7
`define DDC_BIT_MIXER_ENA 6
`define DDC_BIT_MIXER_GAIN 5
`define DDC_BIT_NCO_ENA 4
`define DDC_BIT_REVBUS 3
`define DDC_BIT_TWOS 1
`define DDC_BIT_TXEN 0
`define DDC_CUR_MSB 15
`define DDC_CUR_LSB 12
`define DDC_BIT_CHECK_ENA 15
`endif

// [hw/ddc_pkg.sv]
package ddc_pkg;
    typedef enum logic [1:0] {DDC_IDLE, DDC_ACCESS} ddc_apb_state_t;
    typedef logic [15:0] ddc_word_t;
endpackage

// [hw/ddc_regs.sv]
// Behaviour
// - Datapath control bit 7 selects a four-wire serial port when set and three-wire when clear.
// - Datapath control bit 6 enables the mixer.
// - Datapath control bit 5 adds 6dB of gain to the mixer output.
// - Datapath control bit 4 enables the oscillator, which coarse mixing does not need.
// - Datapath control bit 3 reverses the input data bus bit order.
// - Datapath control bit 1 selects two's complement input, else offset binary.
// - The datapath control register sits at index 0x02 and resets to 0x7000.
// - The output current register sits at index 0x03 and resets to 0xf000.
// - Output current bits 15:12 choose full scale in 16 steps, resetting to all ones.
// - Output current bit 0 sets the internal transmit enable and resets to zero.
// - Transmission is on when the software bit or the external pin is high.
// - Each pattern result bit flags a failure of the same input data bit.
// - Pattern results are gathered only while the checker enable bit 15 is set.
// - The pattern result register at index 0x04 is cleared by any write.
// - A mismatch between valid captured data and the test pattern raises an alarm while the checker enable bit 15 is set.
`include "ddc_defs.svh"
module ddc_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [15:0] data_in,
    input wire ddc_pkg::ddc_word_t pattern_in,
    input wire logic data_valid,
    input wire logic txenable_pin,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic serial_port_four_wire_select,
    output logic mixer_ena,
    output logic mixer_gain_6db,
    output logic nco_ena,
    output logic revbus_ena,
    output logic twos_ena,
    output logic [3:0] full_scale_step,
    output logic tx_enable,
    output logic pattern_alarm,
    output logic irq
);
    import ddc_pkg::*;

    logic [15:0] datapath_control_ff;
    logic [15:0] output_current_control_ff;
    logic [15:0] pattern_check_result_ff;
    logic check_ena_ff;
    logic irq_status_ff;
    logic irq_mask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic tx_enable_ff;
    logic pattern_alarm_ff;
    logic irq_ff;
    logic [15:0] nxt_fail;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic dp_write;
    logic cur_write;
    logic pat_write;
    logic pattern_known_ff;

    // Access is taken at the first penable cycle; pready answers the next.
    assign wr_en = psel && penable && !pready_ff && pwrite;
    assign rd_en = psel && penable && !pready_ff && !pwrite;
    always_comb begin
        if (paddr == `DDC_OFF_DATAPATH) begin
            hit = 1'b1;
        end else if (paddr == `DDC_OFF_CURRENT) begin
            hit = 1'b1;
        end else if (paddr == `DDC_OFF_PATTERN) begin
            hit = 1'b1;
        end else if (paddr == `DDC_OFF_IRQ_STATUS) begin
            hit = 1'b1;
        end else if (paddr == `DDC_OFF_IRQ_MASK) begin
            hit = 1'b1;
        end else if (paddr == `DDC_OFF_CHECK_CTRL) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // Bit i of the result compares data bit i with pattern bit i, as the bits arrive on the bus.
    assign nxt_fail = (data_in ^ pattern_in) & {16{data_valid && check_ena_ff}};

    assign dp_write = wr_en && paddr == `DDC_OFF_DATAPATH && pstrb[0] && pstrb[1];
    assign cur_write = wr_en && paddr == `DDC_OFF_CURRENT && pstrb[0] && pstrb[1];
    assign pat_write = wr_en && paddr == `DDC_OFF_PATTERN;

    // Marks the result register as known once written, so checks skip its power-up content.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_known_ff <= 1'b0;
        end else if (pat_write) begin
            pattern_known_ff <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            datapath_control_ff <= `DDC_RST_DATAPATH;
        end else if (wr_en && paddr == `DDC_OFF_DATAPATH && pstrb[0] && pstrb[1]) begin
            datapath_control_ff <= pwdata[15:0] & `DDC_DP_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_current_control_ff <= `DDC_RST_CURRENT;
        end else if (wr_en && paddr == `DDC_OFF_CURRENT && pstrb[0] && pstrb[1]) begin
            output_current_control_ff <= pwdata[15:0] & `DDC_CUR_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            check_ena_ff <= 1'b0;
            irq_mask_ff <= 1'b0;
        end else if (wr_en && paddr == `DDC_OFF_CHECK_CTRL) begin
            check_ena_ff <= pwdata[`DDC_BIT_CHECK_ENA];
        end else if (wr_en && paddr == `DDC_OFF_IRQ_MASK) begin
            irq_mask_ff <= pwdata[0];
        end
    end

    // Results have no reset value; a write clears, new failures win over that clear.
    always_ff @(posedge pclk) begin
        if (wr_en && paddr == `DDC_OFF_PATTERN) begin
            pattern_check_result_ff <= nxt_fail;
        end else begin
            pattern_check_result_ff <= pattern_check_result_ff | nxt_fail;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= 1'b0;
        end else if (|nxt_fail) begin
            irq_status_ff <= 1'b1;
        end else if (wr_en && paddr == `DDC_OFF_IRQ_STATUS && pwdata[0]) begin
            irq_status_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_enable_ff <= 1'b0;
            pattern_alarm_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            tx_enable_ff <= output_current_control_ff[`DDC_BIT_TXEN] || txenable_pin;
            pattern_alarm_ff <= |nxt_fail;
            irq_ff <= irq_status_ff && irq_mask_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
        end else if (rd_en) begin
            if (paddr == `DDC_OFF_DATAPATH) begin
                prdata_ff <= {16'h0, datapath_control_ff};
            end else if (paddr == `DDC_OFF_CURRENT) begin
                prdata_ff <= {16'h0, output_current_control_ff};
            end else if (paddr == `DDC_OFF_PATTERN) begin
                prdata_ff <= {16'h0, pattern_check_result_ff};
            end else if (paddr == `DDC_OFF_IRQ_STATUS) begin
                prdata_ff <= {31'h0, irq_status_ff};
            end else if (paddr == `DDC_OFF_IRQ_MASK) begin
                prdata_ff <= {31'h0, irq_mask_ff};
            end else if (paddr == `DDC_OFF_CHECK_CTRL) begin
                prdata_ff <= {16'h0, check_ena_ff, 15'h0};
            end else begin
                prdata_ff <= 32'h0;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign serial_port_four_wire_select = datapath_control_ff[`DDC_BIT_FOUR_WIRE];
    assign mixer_ena = datapath_control_ff[`DDC_BIT_MIXER_ENA];
    assign mixer_gain_6db = datapath_control_ff[`DDC_BIT_MIXER_GAIN];
    assign nco_ena = datapath_control_ff[`DDC_BIT_NCO_ENA];
    assign revbus_ena = datapath_control_ff[`DDC_BIT_REVBUS];
    assign twos_ena = datapath_control_ff[`DDC_BIT_TWOS];
    assign full_scale_step = output_current_control_ff[`DDC_CUR_MSB:`DDC_CUR_LSB];
    assign tx_enable = tx_enable_ff;
    assign pattern_alarm = pattern_alarm_ff;
    assign irq = irq_ff;

    a_dp_reset: assert property (@(posedge pclk) $rose(presetn) |-> datapath_control_ff == 16'h7000)
        else $error("datapath control not at reset value");
    a_cur_reset: assert property (@(posedge pclk) $rose(presetn) |-> output_current_control_ff == 16'hf000)
        else $error("output current not at reset value");
    a_dp_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 12'h008 && pstrb == 4'hf |=> datapath_control_ff == ($past(pwdata[15:0]) & 16'hf0fa))
        else $error("datapath control write lost");
    a_mixer_out: assert property (@(posedge pclk) disable iff (!presetn)
        mixer_ena == datapath_control_ff[6] && mixer_gain_6db == datapath_control_ff[5])
        else $error("mixer outputs wrong");
    a_tx_or: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 tx_enable == $past(output_current_control_ff[0] || txenable_pin))
        else $error("transmit enable not OR of sources");
    a_fail_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        $past(check_ena_ff && data_valid) && $past(data_in[0] != pattern_in[0]) |-> pattern_check_result_ff[0])
        else $error("failure flag not set");
    a_pat_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == 12'h010 && !check_ena_ff |=> pattern_check_result_ff == 16'h0)
        else $error("pattern result not cleared");
    a_no_check: assert property (@(posedge pclk) disable iff (!presetn)
        !check_ena_ff |-> nxt_fail == 16'h0)
        else $error("flags gathered while checker off");
    a_alarm_irq: assert property (@(posedge pclk) disable iff (!presetn)
        pattern_alarm |-> irq_status_ff)
        else $error("alarm without status");
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held too long");
    a_four_wire_wr: assert property (@(posedge pclk) disable iff (!presetn)
        dp_write |=> serial_port_four_wire_select == $past(pwdata[7]))
        else $error("four-wire select not written");
    a_mixer_wr: assert property (@(posedge pclk) disable iff (!presetn)
        dp_write |=> mixer_ena == $past(pwdata[6]))
        else $error("mixer enable not written");
    a_gain_wr: assert property (@(posedge pclk) disable iff (!presetn)
        dp_write |=> mixer_gain_6db == $past(pwdata[5]))
        else $error("mixer gain not written");
    a_nco_wr: assert property (@(posedge pclk) disable iff (!presetn)
        dp_write |=> nco_ena == $past(pwdata[4]))
        else $error("oscillator enable not written");
    a_revbus_wr: assert property (@(posedge pclk) disable iff (!presetn)
        dp_write |=> revbus_ena == $past(pwdata[3]))
        else $error("bus reversal not written");
    a_twos_wr: assert property (@(posedge pclk) disable iff (!presetn)
        dp_write |=> twos_ena == $past(pwdata[1]))
        else $error("number format not written");
    a_dp_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !dp_write |=> $stable(datapath_control_ff))
        else $error("datapath control changed without write");
    a_dp_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (datapath_control_ff & 16'h0f05) == 16'h0)
        else $error("datapath reserved bit set");
    a_cur_write: assert property (@(posedge pclk) disable iff (!presetn)
        cur_write |=> output_current_control_ff == ($past(pwdata[15:0]) & 16'hf001))
        else $error("output current write lost");
    a_cur_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !cur_write |=> $stable(output_current_control_ff))
        else $error("output current changed without write");
    a_cur_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `DDC_OFF_CURRENT && !(pstrb[0] && pstrb[1]) |=> $stable(output_current_control_ff))
        else $error("partial strobe write taken");
    a_step_wr: assert property (@(posedge pclk) disable iff (!presetn)
        cur_write |=> full_scale_step == $past(pwdata[15:12]))
        else $error("full scale step not written");
    a_cur_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (output_current_control_ff & 16'h0ffe) == 16'h0)
        else $error("output current reserved bit set");
    a_tx_soft: assert property (@(posedge pclk) disable iff (!presetn)
        output_current_control_ff[0] |=> tx_enable)
        else $error("software transmit enable ignored");
    a_tx_pin: assert property (@(posedge pclk) disable iff (!presetn)
        txenable_pin |=> tx_enable)
        else $error("transmit pin ignored");
    a_tx_off: assert property (@(posedge pclk) disable iff (!presetn)
        !output_current_control_ff[0] && !txenable_pin |=> !tx_enable)
        else $error("transmit enabled with both sources low");
    a_fail_set: assert property (@(posedge pclk) disable iff (!presetn)
        check_ena_ff && data_valid |=>
        (pattern_check_result_ff & $past(data_in ^ pattern_in)) == $past(data_in ^ pattern_in))
        else $error("failing bit not flagged");
    a_fail_keep: assert property (@(posedge pclk) disable iff (!presetn)
        pattern_known_ff && !pat_write |=>
        (pattern_check_result_ff & $past(pattern_check_result_ff)) == $past(pattern_check_result_ff))
        else $error("failure flag dropped");
    a_pat_write: assert property (@(posedge pclk) disable iff (!presetn)
        pat_write |=> pattern_check_result_ff == $past(nxt_fail))
        else $error("pattern result write did not clear");
    a_fail_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !data_valid |-> nxt_fail == 16'h0)
        else $error("flags gathered without valid data");
    a_alarm_set: assert property (@(posedge pclk) disable iff (!presetn)
        |nxt_fail |=> pattern_alarm)
        else $error("mismatch raised no alarm");
    a_alarm_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        nxt_fail == 16'h0 |=> !pattern_alarm)
        else $error("alarm without mismatch");
    a_status_set: assert property (@(posedge pclk) disable iff (!presetn)
        |nxt_fail |=> irq_status_ff)
        else $error("mismatch did not set status");
    a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `DDC_OFF_IRQ_STATUS && pwdata[0] && nxt_fail == 16'h0 |=> !irq_status_ff)
        else $error("status not cleared by write of one");
    a_status_keep: assert property (@(posedge pclk) disable iff (!presetn)
        irq_status_ff && !(wr_en && paddr == `DDC_OFF_IRQ_STATUS) |=> irq_status_ff)
        else $error("status dropped without write");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> irq == $past(irq_status_ff && irq_mask_ff))
        else $error("interrupt does not follow masked status");
    a_mask_wr: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `DDC_OFF_IRQ_MASK |=> irq_mask_ff == $past(pwdata[0]))
        else $error("interrupt mask not written");
    a_check_wr: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `DDC_OFF_CHECK_CTRL |=> check_ena_ff == $past(pwdata[`DDC_BIT_CHECK_ENA]))
        else $error("checker enable not written");
    a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("access not answered");
    a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable) |=> !pready)
        else $error("pready without access");
    a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && hit |=> !pslverr)
        else $error("error on mapped address");
    a_read_dp: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == `DDC_OFF_DATAPATH |=> prdata == {16'h0, $past(datapath_control_ff)})
        else $error("datapath control read wrong");
    a_read_cur: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == `DDC_OFF_CURRENT |=> prdata == {16'h0, $past(output_current_control_ff)})
        else $error("output current read wrong");
    a_read_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && !hit |=> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

// [verification/tb_top.sv]
`include "ddc_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, data_valid = 0, txenable_pin = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [3:0] pstrb = 4'hf;
    logic [15:0] data_in = 0;
    ddc_pkg::ddc_word_t pattern_in = 0;
    logic [31:0] prdata;
    logic pready, pslverr, serial_port_four_wire_select, mixer_ena, mixer_gain_6db, nco_ena, revbus_ena;
    logic twos_ena, tx_enable, pattern_alarm, irq;
    logic [3:0] full_scale_step;
    int mismatches = 0, n_compared = 0, cyc = 0;
    always #25 pclk = ~pclk;
    ddc_regs ddc_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .data_in,
        .pattern_in, .data_valid, .txenable_pin, .prdata, .pready, .pslverr, .serial_port_four_wire_select,
        .mixer_ena, .mixer_gain_6db, .nco_ena, .revbus_ena, .twos_ena, .full_scale_step, .tx_enable,
        .pattern_alarm, .irq);
    task test_done;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            test_done;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    // One APB transfer; the request is held until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1, a, d, r, e);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x, input string m);
        logic [31:0] r;
        logic e;
        apb(0, a, 0, r, e);
        chk(r, x, m);
    endtask
    task miss(input logic [15:0] d, input logic [15:0] p, input logic x);
        @(posedge pclk);
        data_in <= d; pattern_in <= p; data_valid <= 1;
        @(posedge pclk);
        data_valid <= 0;
        @(negedge pclk);
        chk(pattern_alarm, x, "alarm");
    endtask
    task t_reset;
        rd(`DDC_OFF_DATAPATH, 32'h7000, "datapath reset");
        rd(`DDC_OFF_CURRENT, 32'hf000, "current reset");
        chk(full_scale_step, 4'hf, "step reset");
        chk(tx_enable, 0, "tx reset");
    endtask
    task t_datapath;
        int b[6] = '{7, 6, 5, 4, 3, 1};
        for (int j = 0; j < 6; j++) begin
            wr(`DDC_OFF_DATAPATH, 32'h1 << b[j]);
            chk({serial_port_four_wire_select, mixer_ena, mixer_gain_6db, nco_ena, revbus_ena, twos_ena},
                6'h20 >> j, "datapath bit");
        end
        wr(`DDC_OFF_DATAPATH, 32'hf0fa);
        rd(`DDC_OFF_DATAPATH, 32'hf0fa, "datapath readback");
    endtask
    task t_current;
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 2; s++) begin
                wr(`DDC_OFF_CURRENT, 32'h3000 | s);
                txenable_pin <= p[0];
                repeat (2) @(posedge pclk);
                chk(tx_enable, p | s, "tx enable");
            end
        end
        chk(full_scale_step, 4'h3, "step");
        rd(`DDC_OFF_CURRENT, 32'h3001, "current readback");
        pstrb <= 4'hc;
        wr(`DDC_OFF_CURRENT, 32'h5000);
        pstrb <= 4'hf;
        rd(`DDC_OFF_CURRENT, 32'h3001, "strobe refused");
    endtask
    task t_pattern;
        logic [31:0] r;
        logic e;
        wr(`DDC_OFF_CHECK_CTRL, 32'h8000);
        wr(`DDC_OFF_PATTERN, 0);
        rd(`DDC_OFF_PATTERN, 0, "pattern clear");
        miss(16'hda5b, 16'h5a5a, 1);
        chk(irq, 0, "irq masked");
        miss(16'h01ff, 16'h00ff, 1);
        miss(16'h1234, 16'h1234, 0);
        rd(`DDC_OFF_PATTERN, 32'h8101, "pattern sticky");
        wr(`DDC_OFF_CHECK_CTRL, 0);
        miss(16'h0002, 16'h0000, 0);
        rd(`DDC_OFF_PATTERN, 32'h8101, "checker off");
        wr(`DDC_OFF_PATTERN, 32'h1234);
        rd(`DDC_OFF_PATTERN, 0, "write clears");
        wr(`DDC_OFF_IRQ_MASK, 1);
        repeat (2) @(posedge pclk);
        chk(irq, 1, "irq unmasked");
        rd(`DDC_OFF_IRQ_STATUS, 1, "status set");
        wr(`DDC_OFF_IRQ_STATUS, 1);
        repeat (2) @(posedge pclk);
        chk(irq, 0, "irq cleared");
        apb(0, 12'h0f0, 0, r, e);
        chk(r, 0, "unmapped read");
        chk(e, 1, "unmapped error");
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_datapath;
        t_current;
        t_pattern;
        test_done;
    end
endmodule
